/* testbench/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CAT = 8'h5A; // Arbitrary value
  localparam logic [7:0] PLO = 8'hC3; // Arbitrary value
  localparam logic [7:0] PHI = 8'h3C; // Arbitrary value
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  localparam int LIMIT = 90000;
  // Address, writable mask, reset value
  localparam logic [23:0] RWT [19] = '{24'h11_FF6C, 24'h12_5000, 24'h13_7F20,
    24'h1F_DB00, 24'h20_FB00, 24'h21_9F00, 24'h32_FF00, 24'h33_0100,
    24'h34_0700, 24'h35_FF00, 24'h36_FF00, 24'h3A_FF00, 24'h40_0303,
    24'h41_FFFF, 24'h42_0303, 24'h43_FFFF, 24'h47_FF00, 24'h50_8300,
    24'h51_FF00};
  localparam logic [7:0] ROA [17] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h14,
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30, 8'h38, 8'h39, 8'h3B, 8'h3C,
    8'h3D, 8'h3E};
  localparam logic [7:0] STK [4] = '{8'h25, 8'h3B, 8'h38, 8'h39};
  // Protect control, then alarm, tx enable, blanking, expected
  localparam logic [11:0] PT [7] = '{12'h0C1, 12'h08E, 12'h205, 12'h20A,
    12'h409, 12'h103, 12'h00E};
  localparam logic [7:0] MT [4] = '{8'h00, 8'h40, 8'h10, 8'hFF};
  logic sys_clk, arst_n, spi_sclk, spi_cs_n, spi_sdio_in;
  logic spi_sdio_out, spi_sdio_oe, spi_sdo_out, spi_sdo_oe;
  logic txen_pin, power_detect_alarm, blanking_active, irq, protect_out;
  logic [3:0] power_state_in, align_events_in, align_mode_select, sticky;
  logic [7:0] irq_events_pll_fifo, irq_events_datapath, overflow_in;
  logic power_detect_error, osc_align_event, offset_overflow_in;
  logic align_busy, align_result_strobe, present_underrun, present_overrun;
  logic [5:0] link_errors_in;
  logic [8:0] present_error_in, align_delay;
  logic [4:0] thermometer_in;
  logic thermometer_previous, converter_a_enable, clock_a_enable;
  logic [2:0] osc_align_results, align_tolerance;
  logic [7:0] power_down_controls, align_delay_counter;
  logic [7:0] align_reference_counter, oscillator_i_key, sh;
  logic align_enable, align_arm, oscillator_align_arm, tb_oe, tb_d, lsb, mb;
  logic [3:0] i_coarse_latency, q_coarse_latency;
  logic [9:0] i_fullscale_code, q_fullscale_code;
  logic [1:0] oscillator_align_mode;
  logic [10:0] prev;
  logic [31:0] rnd;
  logic [7:0] wv [0:255];
  logic [7:0] exp_q [$];
  logic [14:0] adr_q [$];
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int nb = 0;

  // Shared data line idles high through its pull-up
  assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (tb_oe ? tb_d : 1'b1);

  ddc_config_regs #(.CATEGORY_ID(CAT), .PART_LO_ID(PLO), .PART_HI_ID(PHI),
    .REVISION_ID(REV)) dut (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [63:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] ro_exp(input logic [7:0] a);
    case (a)
      8'h03: return CAT;
      8'h04: return PLO;
      8'h05: return PHI;
      8'h06: return {4'h0, REV};
      8'h14: return {2'b00, power_state_in[3:2], 2'b00, power_state_in[1:0]};
      8'h23: return irq_events_pll_fifo & 8'hDB;
      8'h24: return irq_events_datapath & 8'hFB;
      8'h25: return {power_detect_error, 2'b00, osc_align_event, sticky};
      8'h26: return overflow_in;
      8'h27: return {7'h00, offset_overflow_in};
      8'h30: return {2'b00, link_errors_in};
      8'h38: return prev[7:0];
      8'h39: return {prev[10:9], 5'h00, prev[8]};
      8'h3B: return {align_busy, 3'b000, sticky};
      8'h3C: return present_error_in[7:0];
      8'h3D: return {present_underrun, present_overrun, 5'h00,
                     present_error_in[8]};
      8'h3E: return {thermometer_previous, 2'b00, thermometer_in};
      default: return 8'h00;
    endcase
  endfunction : ro_exp

  task automatic cw(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cw

  task automatic sbit(input logic b);
    tb_d = b;
    cw(6);
    spi_sclk = 1'b1;
    cw(6);
    spi_sclk = 1'b0;
  endtask : sbit

  task automatic xfer(input logic r, input logic [14:0] a, input int n,
                      input logic [15:0] d);
    logic [15:0] ins;
    logic [7:0] byt;
    ins = {r, a};
    spi_cs_n = 1'b0;
    tb_oe = 1'b1;
    cw(6);
    for (int i = 0; i < 16; i++) sbit(lsb ? ins[i] : ins[15-i]);
    tb_oe = ~r;
    for (int k = 0; k < n; k++) begin
      byt = (k == 0) ? d[15:8] : d[7:0];
      if (r) begin
        exp_q.push_back(byt);
        adr_q.push_back(a);
      end
      for (int i = 0; i < 8; i++) sbit(lsb ? byt[i] : byt[7-i]);
    end
    cw(6);
    spi_cs_n = 1'b1;
    tb_oe = 1'b0;
    cw(8);
  endtask : xfer

  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    xfer(1'b0, a, 1, {v, 8'h00});
  endtask : wr

  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 1, {e, 8'h00});
  endtask : rd

  always @(posedge spi_sclk) begin
    if (spi_sdo_oe === 1'b1 || spi_sdio_oe === 1'b1) begin
      mb = (spi_sdo_oe === 1'b1) ? spi_sdo_out : spi_sdio_out;
      sh = lsb ? {mb, sh[7:1]} : {sh[6:0], mb};
      nb++;
      if (nb == 8) begin
        nb = 0;
        check($sformatf("reg %h", adr_q.pop_front()), sh, exp_q.pop_front());
      end
    end
  end

  always @(posedge spi_cs_n) nb = 0;

  initial begin
    {spi_sclk, tb_oe, tb_d, lsb, txen_pin, power_detect_alarm} = '0;
    {blanking_active, align_events_in, align_result_strobe, sticky} = '0;
    {power_state_in, irq_events_pll_fifo, irq_events_datapath} = '0;
    {overflow_in, power_detect_error, osc_align_event, prev} = '0;
    {offset_overflow_in, align_busy, link_errors_in, present_error_in} = '0;
    {present_underrun, present_overrun, thermometer_in} = '0;
    {thermometer_previous, osc_align_results} = '0;
    spi_cs_n = 1'b1;
    rnd = 32'h0000_3610;
    arst_n = 1'b0;
    cw(3);
    arst_n = 1'b1;
    cw(4);
    rd(15'h0000, 8'h00);
    for (int i = 0; i < 19; i++) rd({7'h00, RWT[i][23:16]}, RWT[i][7:0]);
    wr(15'h0060, 8'hFF);
    rd(15'h0060, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 19; i++) begin
      rnd = lfsr(rnd);
      wv[RWT[i][23:16]] = rnd[7:0] & RWT[i][15:8];
      wr({7'h00, RWT[i][23:16]}, rnd[7:0]);
      rd({7'h00, RWT[i][23:16]}, wv[RWT[i][23:16]]);
    end
    check("fields", {power_down_controls, align_delay, align_tolerance,
      i_fullscale_code, q_fullscale_code, i_coarse_latency, q_coarse_latency,
      oscillator_i_key}, {wv[8'h11], wv[8'h33][0], wv[8'h32], wv[8'h34][2:0],
      wv[8'h40][1:0], wv[8'h41], wv[8'h42][1:0], wv[8'h43], wv[8'h47],
      wv[8'h51]});
    check("ctl", {align_enable, align_arm, align_mode_select,
      oscillator_align_arm, oscillator_align_mode, align_delay_counter,
      align_reference_counter}, {wv[8'h3A][7:6], wv[8'h3A][3:0],
      wv[8'h50][7], wv[8'h50][1:0], wv[8'h35], wv[8'h36]});
    $display("test readback done");
    rnd = lfsr(rnd);
    {power_state_in, irq_events_pll_fifo, irq_events_datapath, overflow_in,
     power_detect_error, osc_align_event, offset_overflow_in, align_busy} = rnd;
    rnd = lfsr(rnd);
    {link_errors_in, present_error_in, present_underrun, present_overrun,
     thermometer_in, thermometer_previous, osc_align_results} = rnd[25:0];
    cw(4);
    check("irq", irq, |{irq_events_pll_fifo & 8'hDB & wv[8'h1F],
      irq_events_datapath & 8'hFB & wv[8'h20],
      {power_detect_error, 2'b00, osc_align_event, 4'h0} & wv[8'h21]});
    foreach (ROA[i]) begin
      wr({7'h00, ROA[i]}, 8'hFF);
      rd({7'h00, ROA[i]}, ro_exp(ROA[i]));
    end
    rd(15'h0050, {wv[8'h50][7], 1'b0, osc_align_results, 1'b0,
                  wv[8'h50][1:0]});
    $display("test status done");
    wr(15'h003A, 8'h00);
    {irq_events_pll_fifo, irq_events_datapath} = '0;
    {power_detect_error, osc_align_event} = '0;
    wr(15'h0021, 8'h0F);
    align_events_in = 4'h5;
    cw(1);
    align_events_in = 4'h0;
    sticky = 4'h5;
    cw(4);
    check("irq", irq, 1'b1);
    wr(15'h0021, 8'h0A);
    check("irq", irq, 1'b0);
    {present_underrun, present_overrun, present_error_in} = 11'h5A5;
    align_result_strobe = 1'b1;
    cw(1);
    align_result_strobe = 1'b0;
    prev = 11'h5A5;
    foreach (STK[i]) rd({7'h00, STK[i]}, ro_exp(STK[i]));
    wr(15'h003A, 8'h30);
    wr(15'h003A, 8'h00);
    sticky = 4'h0;
    prev = '0;
    foreach (STK[i]) rd({7'h00, STK[i]}, ro_exp(STK[i]));
    $display("test sticky done");
    foreach (PT[i]) begin
      {power_detect_alarm, txen_pin, blanking_active} = PT[i][3:1];
      wr(15'h0013, PT[i][11:4]);
      check("protect", protect_out, PT[i][0]);
    end
    txen_pin = 1'b0;
    foreach (MT[i]) begin
      wr(15'h0012, MT[i]);
      check("txmask", {converter_a_enable, clock_a_enable},
            {MT[i][6], MT[i][4]});
    end
    $display("test protect done");
    wr(15'h0000, 8'h81);
    rd(15'h0000, 8'h00);
    rd(15'h0041, 8'hFF);
    check("power", power_down_controls, 8'h6C);
    xfer(1'b0, 15'h0036, 2, 16'hA55A);
    xfer(1'b1, 15'h0036, 2, 16'hA55A);
    check("counts", {align_reference_counter, align_delay_counter},
          16'hA55A);
    wr(15'h0000, 8'h24);
    xfer(1'b0, 15'h0040, 2, 16'h0234);
    check("fullscale", i_fullscale_code, 10'h234);
    wr(15'h0000, 8'h18);
    rd(15'h0011, 8'h6C);
    wr(15'h0000, 8'h42);
    lsb = 1'b1;
    rd(15'h0000, 8'h42);
    rd(15'h0011, 8'h6C);
    wr(15'h0000, 8'h00);
    lsb = 1'b0;
    rd(15'h0000, 8'h00);
    $display("test interface done");
    cw(20);
    check("pending", exp_q.size(), 64'h0);
    end_sim();
  end
endmodule : tb

/* verilog/ddc_config_regs.sv */
// Contract
// - Read-only registers show internal state and ignore writes; others store.
// - Interface config resets 0; reset, bit order, step, output bits mirrored.
// - Power control resets 0x6C; bits power down bandgap, converters, clocks.
// - Transmit mask resets 0; bit 6 converter A, bit 4 clock A.
// - Protect control resets 0x20; routes and software overrides of outputs.
// - Power state shows I/Q powering down bits 5:4, up bits 1:0.
// - Three enables pair bitwise with three status registers onto interrupt.
// - Overflow status flags datapath stages; 0x027 bit 0 offset overflow.
// - Link check bits 5:0 flag link parameter problems in order.
// - Nine-bit delay, 3-bit window, 8-bit delay and reference counts.
// - Alignment control: enable, arm, clear sticky, clear previous, mode.
// - Alignment status: busy bit 7, locked, rotated, window, tripped.
// - Previous and present errors read as 9-bit magnitude with flags.
// - Thermometer register shows five error flags and previous flag.
// - Ten-bit full-scale codes per channel reset to maximum.
// - Coarse latency: I upper nibble, Q lower nibble, reset zero.
// - Oscillator alignment: arm bit 7, results 5:3, mode 1:0.
`include "ddc_regs.svh"

module ddc_config_regs #(
  parameter logic [7:0] CATEGORY_ID = 8'h11, // Arbitrary value
  parameter logic [7:0] PART_LO_ID = 8'h22, // Arbitrary value
  parameter logic [7:0] PART_HI_ID = 8'h33, // Arbitrary value
  parameter logic [3:0] REVISION_ID = 4'h1 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  output logic spi_sdo_out,
  output logic spi_sdo_oe,
  input wire logic txen_pin,
  input wire logic power_detect_alarm,
  input wire logic blanking_active,
  input wire logic [3:0] power_state_in,
  input wire logic [7:0] irq_events_pll_fifo,
  input wire logic [7:0] irq_events_datapath,
  input wire logic power_detect_error,
  input wire logic osc_align_event,
  input wire logic [7:0] overflow_in,
  input wire logic offset_overflow_in,
  input wire logic [5:0] link_errors_in,
  input wire logic align_busy,
  input wire logic [3:0] align_events_in,
  input wire logic align_result_strobe,
  input wire logic [8:0] present_error_in,
  input wire logic present_underrun,
  input wire logic present_overrun,
  input wire logic [4:0] thermometer_in,
  input wire logic thermometer_previous,
  input wire logic [2:0] osc_align_results,
  output logic irq,
  output logic protect_out,
  output logic converter_a_enable,
  output logic clock_a_enable,
  output logic [7:0] power_down_controls,
  output logic [8:0] align_delay,
  output logic [2:0] align_tolerance,
  output logic [7:0] align_delay_counter,
  output logic [7:0] align_reference_counter,
  output logic align_enable,
  output logic align_arm,
  output logic [3:0] align_mode_select,
  output logic [9:0] i_fullscale_code,
  output logic [9:0] q_fullscale_code,
  output logic [3:0] i_coarse_latency,
  output logic [3:0] q_coarse_latency,
  output logic oscillator_align_arm,
  output logic [1:0] oscillator_align_mode,
  output logic [7:0] oscillator_i_key
);
  localparam logic [19:0][7:0] RW_MASK = {
    8'hFF, `DDC_M_OSC, 8'hFF, 8'hFF, `DDC_M_FS_HI, 8'hFF, `DDC_M_FS_HI,
    8'hFF, 8'hFF, 8'hFF, `DDC_M_WIN, `DDC_M_DLY_HI, 8'hFF,
    `DDC_M_IRQ2, `DDC_M_IRQ1, `DDC_M_IRQ0, `DDC_M_PROT, `DDC_M_TXMASK,
    8'hFF, 8'hFF};
  localparam logic [19:0][7:0] RW_RST = {
    8'h00, 8'h00, 8'h00, `DDC_RST_FS_LO, `DDC_RST_FS_HI, `DDC_RST_FS_LO,
    `DDC_RST_FS_HI, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, `DDC_RST_PROT, 8'h00, `DDC_RST_PWR, 8'h00};

  ddc_pkg::ddc_core_t st;
  ddc_pkg::ddc_core_t next_st;
  logic sclk_q;
  logic cs_n_q;
  logic din_q;
  logic txen_q;
  logic [3:0] align_sticky;
  logic low_first;
  logic step_up;
  logic sdo_en;
  logic txen_eff;
  logic drive;

  ddc_sync #(
    .W(4),
    .INIT(4'b0100)
  ) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .d({spi_sclk, spi_cs_n, spi_sdio_in, txen_pin}),
    .q({sclk_q, cs_n_q, din_q, txen_q})
  );

  ddc_sticky #(
    .W(4)
  ) u_sticky (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .set(align_events_in),
    .clear(st.rw[12][5]),
    .q(align_sticky)
  );

  // Maps a writable address to its storage slot
  function automatic logic [5:0] rw_slot(input logic [14:0] a);
    unique case (a)
      `DDC_A_INTF: rw_slot = {1'b1, 5'd0};
      `DDC_A_PWR: rw_slot = {1'b1, 5'd1};
      `DDC_A_TXMASK: rw_slot = {1'b1, 5'd2};
      `DDC_A_PROT: rw_slot = {1'b1, 5'd3};
      `DDC_A_IEN0: rw_slot = {1'b1, 5'd4};
      `DDC_A_IEN1: rw_slot = {1'b1, 5'd5};
      `DDC_A_IEN2: rw_slot = {1'b1, 5'd6};
      `DDC_A_DLY_LO: rw_slot = {1'b1, 5'd7};
      `DDC_A_DLY_HI: rw_slot = {1'b1, 5'd8};
      `DDC_A_WIN: rw_slot = {1'b1, 5'd9};
      `DDC_A_DCNT: rw_slot = {1'b1, 5'd10};
      `DDC_A_RCNT: rw_slot = {1'b1, 5'd11};
      `DDC_A_ACTL: rw_slot = {1'b1, 5'd12};
      `DDC_A_IFS_HI: rw_slot = {1'b1, 5'd13};
      `DDC_A_IFS_LO: rw_slot = {1'b1, 5'd14};
      `DDC_A_QFS_HI: rw_slot = {1'b1, 5'd15};
      `DDC_A_QFS_LO: rw_slot = {1'b1, 5'd16};
      `DDC_A_LAT: rw_slot = {1'b1, 5'd17};
      `DDC_A_OSC: rw_slot = {1'b1, 5'd18};
      `DDC_A_OKEY: rw_slot = {1'b1, 5'd19};
      default: rw_slot = 6'h00;
    endcase
  endfunction : rw_slot

  function automatic logic [7:0] rd_byte(input ddc_pkg::ddc_core_t s,
                                         input logic [14:0] a);
    logic [5:0] slot;
    slot = rw_slot(a);
    unique case (a)
      `DDC_A_CAT_ID: rd_byte = CATEGORY_ID;
      `DDC_A_PART_LO: rd_byte = PART_LO_ID;
      `DDC_A_PART_HI: rd_byte = PART_HI_ID;
      `DDC_A_REV: rd_byte = {4'h0, REVISION_ID};
      `DDC_A_PSTATE: rd_byte = {2'b00, power_state_in[3:2], 2'b00,
                                power_state_in[1:0]};
      `DDC_A_IST0: rd_byte = irq_events_pll_fifo & `DDC_M_IRQ0;
      `DDC_A_IST1: rd_byte = irq_events_datapath & `DDC_M_IRQ1;
      `DDC_A_IST2: rd_byte = {power_detect_error, 2'b00, osc_align_event,
                              align_sticky};
      `DDC_A_OVF0: rd_byte = overflow_in;
      `DDC_A_OVF1: rd_byte = {7'h00, offset_overflow_in};
      `DDC_A_LINK: rd_byte = {2'b00, link_errors_in};
      `DDC_A_PERR_LO: rd_byte = s.prev_err[7:0];
      `DDC_A_PERR_HI: rd_byte = {s.prev_under, s.prev_over, 5'h00,
                                 s.prev_err[8]};
      `DDC_A_CERR_LO: rd_byte = present_error_in[7:0];
      `DDC_A_CERR_HI: rd_byte = {present_underrun, present_overrun, 5'h00,
                                 present_error_in[8]};
      `DDC_A_ASTAT: rd_byte = {align_busy, 3'b000, align_sticky};
      `DDC_A_THERM: rd_byte = {thermometer_previous, 2'b00, thermometer_in};
      `DDC_A_OSC: rd_byte = {s.rw[18][7], 1'b0, osc_align_results, 1'b0,
                             s.rw[18][1:0]};
      default: rd_byte = slot[5] ? (s.rw[slot[4:0]] & RW_MASK[slot[4:0]])
                                 : 8'h00;
    endcase
  endfunction : rd_byte

  // mirrored controls: either copy of a bit turns it on
  assign low_first = st.rw[0][`DDC_B_LOW_FIRST] |
                     st.rw[0][7 - `DDC_B_LOW_FIRST];
  assign step_up = st.rw[0][`DDC_B_STEP_UP] | st.rw[0][7 - `DDC_B_STEP_UP];
  assign sdo_en = st.rw[0][`DDC_B_SDO_EN] | st.rw[0][7 - `DDC_B_SDO_EN];
  assign txen_eff = st.rw[3][1] ? st.rw[3][0] : txen_q;

  always_comb begin
    logic [15:0] shin;
    logic [15:0] instr;
    logic [7:0] wbyte;
    logic [5:0] slot;
    logic [14:0] next_addr;
    shin = {st.shreg[14:0], din_q};
    instr = low_first ? {<<{shin}} : shin;
    wbyte = low_first ? {<<{shin[7:0]}} : shin[7:0];
    slot = rw_slot(st.addr);
    next_addr = step_up ? st.addr + 15'h0001 : st.addr - 15'h0001;
    next_st = st;
    next_st.sclk_d = sclk_q;
    next_st.soft_rst_pulse = 1'b0;
    if (cs_n_q) begin
      next_st.phase = ddc_pkg::DDC_IDLE;
      next_st.bitcnt = 4'h0;
    end else begin
      unique case (st.phase)
        ddc_pkg::DDC_IDLE: begin
          next_st.phase = ddc_pkg::DDC_INSTR;
          next_st.bitcnt = 4'h0;
        end
        ddc_pkg::DDC_INSTR: begin
          if (sclk_q && !st.sclk_d) begin
            next_st.shreg = shin;
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'hF) begin
              next_st.rd = instr[15];
              next_st.addr = instr[14:0];
              next_st.phase = ddc_pkg::DDC_DATA;
              next_st.bitcnt = 4'h0;
              next_st.outbyte = rd_byte(st, instr[14:0]);
            end
          end
        end
        ddc_pkg::DDC_DATA: begin
          if (sclk_q && !st.sclk_d) begin
            next_st.shreg = shin;
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
              next_st.bitcnt = 4'h0;
              next_st.addr = next_addr;
              next_st.outbyte = rd_byte(st, next_addr);
              // only writable slots store, reserved bits masked
              if (!st.rd && slot[5]) begin
                next_st.rw[slot[4:0]] = wbyte & RW_MASK[slot[4:0]];
              end
              // software reset restores every writable register default, itself included
              if (!st.rd && st.addr == `DDC_A_INTF &&
                  (wbyte[`DDC_B_SOFT_RST] || wbyte[7 - `DDC_B_SOFT_RST]))
              begin
                next_st.rw = RW_RST;
                next_st.soft_rst_pulse = 1'b1;
              end
            end
          end else if (!sclk_q && st.sclk_d && st.rd) begin
            next_st.out_bit = low_first ? st.outbyte[st.bitcnt[2:0]]
                                        : st.outbyte[3'd7 - st.bitcnt[2:0]];
          end
        end
        default: begin
          next_st.phase = ddc_pkg::DDC_IDLE;
        end
      endcase
    end
    if (align_result_strobe) begin
      next_st.prev_err = present_error_in;
      next_st.prev_under = present_underrun;
      next_st.prev_over = present_overrun;
    end else if (st.rw[12][4]) begin
      next_st.prev_err = 9'h000;
      next_st.prev_under = 1'b0;
      next_st.prev_over = 1'b0;
    end
    next_st.protect = st.rw[3][3] ? st.rw[3][2] :
      |(st.rw[3][6:4] & {power_detect_alarm, txen_eff, blanking_active});
    next_st.conv_a_en = st.rw[2][6] | txen_eff;
    next_st.clk_a_en = st.rw[2][4] | txen_eff;
    // enables gate status onto the interrupt
    next_st.irq = |(irq_events_pll_fifo & st.rw[4] & `DDC_M_IRQ0) |
                  |(irq_events_datapath & st.rw[5] & `DDC_M_IRQ1) |
                  |({power_detect_error, 2'b00, osc_align_event,
                     align_sticky} & st.rw[6]);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.rw <= RW_RST;
    end else begin
      st <= next_st;
    end
  end

  // Read data leaves on the pin chosen by the output-enable control
  assign drive = !cs_n_q && st.phase == ddc_pkg::DDC_DATA && st.rd;
  assign spi_sdio_out = st.out_bit;
  assign spi_sdo_out = st.out_bit;
  assign spi_sdio_oe = drive && !sdo_en;
  assign spi_sdo_oe = drive && sdo_en;

  assign irq = st.irq;
  assign protect_out = st.protect;
  assign converter_a_enable = st.conv_a_en;
  assign clock_a_enable = st.clk_a_en;
  assign power_down_controls = st.rw[1];
  assign align_delay = {st.rw[8][0], st.rw[7]};
  assign align_tolerance = st.rw[9][2:0];
  assign align_delay_counter = st.rw[10];
  assign align_reference_counter = st.rw[11];
  assign align_enable = st.rw[12][7];
  assign align_arm = st.rw[12][6];
  assign align_mode_select = st.rw[12][3:0];
  assign i_fullscale_code = {st.rw[13][1:0], st.rw[14]};
  assign q_fullscale_code = {st.rw[15][1:0], st.rw[16]};
  assign i_coarse_latency = st.rw[17][7:4];
  assign q_coarse_latency = st.rw[17][3:0];
  assign oscillator_align_arm = st.rw[18][7];
  assign oscillator_align_mode = st.rw[18][1:0];
  assign oscillator_i_key = st.rw[19];

  property p_soft_reset_power;
    @(posedge sys_clk) disable iff (!arst_n)
    st.soft_rst_pulse |-> power_down_controls == `DDC_RST_PWR &&
      st.rw[0] == 8'h00 && st.rw[3] == `DDC_RST_PROT;
  endproperty
  a_soft_reset_power: assert property (p_soft_reset_power)
    else $error("soft reset left wrong defaults");

  property p_fullscale_max;
    @(posedge sys_clk) disable iff (!arst_n)
    st.soft_rst_pulse |-> i_fullscale_code == 10'h03FF &&
      q_fullscale_code == 10'h03FF && i_coarse_latency == 4'h0;
  endproperty
  a_fullscale_max: assert property (p_fullscale_max)
    else $error("full-scale code not at maximum after reset");

  property p_protect_forced;
    @(posedge sys_clk) disable iff (!arst_n)
    st.rw[3][3] ##1 $stable(st.rw[3][3:2]) |-> protect_out == st.rw[3][2];
  endproperty
  a_protect_forced: assert property (p_protect_forced)
    else $error("forced protect output not followed");

  property p_mask_holds_on;
    @(posedge sys_clk) disable iff (!arst_n)
    st.rw[2][6] ##1 st.rw[2][6] |-> converter_a_enable;
  endproperty
  a_mask_holds_on: assert property (p_mask_holds_on)
    else $error("masked converter followed transmit enable");

  property p_irq_gated;
    @(posedge sys_clk) disable iff (!arst_n)
    (st.rw[4] == 8'h00 && st.rw[5] == 8'h00 && st.rw[6] == 8'h00) [*2]
      |-> !irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt raised with all enables off");

  property p_sticky_clear;
    @(posedge sys_clk) disable iff (!arst_n)
    st.rw[12][5] && align_events_in == 4'h0 |=> align_sticky == 4'h0;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear)
    else $error("sticky alignment flags not cleared");

  property p_previous_capture;
    @(posedge sys_clk) disable iff (!arst_n)
    align_result_strobe |=> st.prev_err == $past(present_error_in) &&
      st.prev_over == $past(present_overrun);
  endproperty
  a_previous_capture: assert property (p_previous_capture)
    else $error("previous error not captured");

  property p_drive_only_reading;
    @(posedge sys_clk) disable iff (!arst_n)
    (spi_sdio_oe || spi_sdo_oe) |-> st.rd && !(spi_sdio_oe && spi_sdo_oe);
  endproperty
  a_drive_only_reading: assert property (p_drive_only_reading)
    else $error("serial output driven outside a read");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!arst_n)
    1'b1 |-> (st.rw[8] & ~`DDC_M_DLY_HI) == 8'h00 &&
      (st.rw[9] & ~`DDC_M_WIN) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit stored");
endmodule : ddc_config_regs

/* verilog/ddc_pkg.sv */
package ddc_pkg;

  typedef enum logic [1:0] {
    DDC_IDLE = 2'b00,
    DDC_INSTR = 2'b01,
    DDC_DATA = 2'b10
  } ddc_phase_t;

  typedef struct packed {
    ddc_phase_t phase;
    logic [3:0] bitcnt;
    logic [15:0] shreg;
    logic [14:0] addr;
    logic rd;
    logic [7:0] outbyte;
    logic sclk_d;
    logic out_bit;
    logic [19:0][7:0] rw;
    logic [8:0] prev_err;
    logic prev_under;
    logic prev_over;
    logic protect;
    logic conv_a_en;
    logic clk_a_en;
    logic irq;
    logic soft_rst_pulse;
  } ddc_core_t;

endpackage : ddc_pkg

/* verilog/ddc_regs.svh */
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// Register offsets
`define DDC_A_INTF 15'h0000
`define DDC_A_CAT_ID 15'h0003
`define DDC_A_PART_LO 15'h0004
`define DDC_A_PART_HI 15'h0005
`define DDC_A_REV 15'h0006
`define DDC_A_PWR 15'h0011
`define DDC_A_TXMASK 15'h0012
`define DDC_A_PROT 15'h0013
`define DDC_A_PSTATE 15'h0014
`define DDC_A_IEN0 15'h001F
`define DDC_A_IEN1 15'h0020
`define DDC_A_IEN2 15'h0021
`define DDC_A_IST0 15'h0023
`define DDC_A_IST1 15'h0024
`define DDC_A_IST2 15'h0025
`define DDC_A_OVF0 15'h0026
`define DDC_A_OVF1 15'h0027
`define DDC_A_LINK 15'h0030
`define DDC_A_DLY_LO 15'h0032
`define DDC_A_DLY_HI 15'h0033
`define DDC_A_WIN 15'h0034
`define DDC_A_DCNT 15'h0035
`define DDC_A_RCNT 15'h0036
`define DDC_A_PERR_LO 15'h0038
`define DDC_A_PERR_HI 15'h0039
`define DDC_A_ACTL 15'h003A
`define DDC_A_ASTAT 15'h003B
`define DDC_A_CERR_LO 15'h003C
`define DDC_A_CERR_HI 15'h003D
`define DDC_A_THERM 15'h003E
`define DDC_A_IFS_HI 15'h0040
`define DDC_A_IFS_LO 15'h0041
`define DDC_A_QFS_HI 15'h0042
`define DDC_A_QFS_LO 15'h0043
`define DDC_A_LAT 15'h0047
`define DDC_A_OSC 15'h0050
`define DDC_A_OKEY 15'h0051

// Non-zero reset values
`define DDC_RST_PWR 8'h6C
`define DDC_RST_PROT 8'h20
`define DDC_RST_FS_HI 8'h03
`define DDC_RST_FS_LO 8'hFF

// Interface configuration bit positions (mirror is 7 - n)
`define DDC_B_SOFT_RST 0
`define DDC_B_LOW_FIRST 1
`define DDC_B_STEP_UP 2
`define DDC_B_SDO_EN 3

// Writable bit masks of partly reserved registers
`define DDC_M_TXMASK 8'h50
`define DDC_M_PROT 8'h7F
`define DDC_M_IRQ0 8'hDB
`define DDC_M_IRQ1 8'hFB
`define DDC_M_IRQ2 8'h9F
`define DDC_M_DLY_HI 8'h01
`define DDC_M_WIN 8'h07
`define DDC_M_FS_HI 8'h03
`define DDC_M_OSC 8'h83

`endif

/* verilog/ddc_sticky.sv */
module ddc_sticky #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] set,
  input wire logic clear,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] flags;
  } ddc_sticky_t;

  ddc_sticky_t st;
  ddc_sticky_t next_st;

  // A set arriving with the clear is kept
  always_comb begin
    next_st.flags = (st.flags & ~{W{clear}}) | set;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.flags;
endmodule : ddc_sticky

/* verilog/ddc_sync.sv */
module ddc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ddc_sync_t;

  ddc_sync_t st;
  ddc_sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : ddc_sync
